// *** logic/dpc_consts.svh ***
// Purpose: Timing counts and field positions for the port controller.
// Assumes: 50 MHz clock; slowest speed grade figures of the memory.
// Notes:   Times are in ns; cycle counts derive from them.
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH

// ----------------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------------
`define DPC_ADDR_W             15
`define DPC_DATA_W             16
`define DPC_TMR_W              4
`define DPC_LANE_UPPER         1
`define DPC_LANE_LOWER         0
`define DPC_FLAG_BIT           0

// ----------------------------------------------------------------------
// Times in ns, as printed
// ----------------------------------------------------------------------
`define DPC_CLK_NS             20
`define DPC_WRITE_PULSE_NS     22
`define DPC_READ_ACCESS_NS     25
`define DPC_READ_CYCLE_NS      25
`define DPC_FLAG_GAP_NS        5
`define DPC_SLAVE_HOLD_NS      13

// ----------------------------------------------------------------------
// Cycle counts: least times round up, at least one cycle
// ----------------------------------------------------------------------
`define DPC_CEIL(ns) (((ns) + `DPC_CLK_NS - 1) / `DPC_CLK_NS)
`define DPC_WRITE_CYC          `DPC_CEIL(`DPC_WRITE_PULSE_NS)
`define DPC_HOLD_CYC           `DPC_CEIL(`DPC_SLAVE_HOLD_NS)
`define DPC_WR_ACCESS_CYC      ((`DPC_WRITE_CYC > `DPC_HOLD_CYC) ? \
                                `DPC_WRITE_CYC : `DPC_HOLD_CYC)
`define DPC_RD_ACCESS_CYC      `DPC_CEIL(`DPC_READ_ACCESS_NS)
`define DPC_GAP_CYC            `DPC_CEIL(`DPC_FLAG_GAP_NS)
`define DPC_POWER_CYC          ((`DPC_READ_CYCLE_NS / `DPC_CLK_NS) + 1)

`endif

// *** logic/dpc_pkg.sv ***
// Purpose: Types shared by the port controller modules.
// Assumes: Nothing beyond the constants header.
// Notes:   States are one-hot.
package dpc_pkg;

    typedef enum logic [1:0] {
        DPC_OP_READ       = 2'h0,
        DPC_OP_WRITE      = 2'h1,
        DPC_OP_FLAG_WRITE = 2'h2,
        DPC_OP_FLAG_READ  = 2'h3
    } dpc_op_t;

    typedef enum logic [5:0] {
        DPC_ST_IDLE  = 6'h01,
        DPC_ST_SETUP = 6'h02,
        DPC_ST_WRITE = 6'h04,
        DPC_ST_READ  = 6'h08,
        DPC_ST_END   = 6'h10,
        DPC_ST_POWER = 6'h20
    } dpc_state_t;

endpackage

// *** logic/dpc_timer_if.sv ***
// Purpose: Carries load, count and done between controller and timer.
// Assumes: One clock domain.
// Notes:   None.
`timescale 1ns/1ps
`include "dpc_consts.svh"

interface dpc_timer_if;
    logic                  load;
    logic [`DPC_TMR_W-1:0] count;
    logic                  done;

    modport ctrl (output load, output count, input done);
    modport cnt  (input load, input count, output done);
endinterface

// *** logic/dpc_timer.sv ***
// Purpose: Down counter that times access phases and power-up wait.
// Assumes: Synchronous active high reset.
// Notes:   Done is high while the remaining count is zero.
`timescale 1ns/1ps
`include "dpc_consts.svh"

module dpc_timer (
    input  wire logic clk,
    input  wire logic reset,
    dpc_timer_if.cnt  tmr
);
    import dpc_pkg::*;

    logic [`DPC_TMR_W-1:0] remain;
    logic [`DPC_TMR_W-1:0] next_remain;

    assign next_remain = tmr.load ? tmr.count :
                         (remain != '0) ? remain - 1'b1 : remain;
    assign tmr.done    = (remain == '0);

    // Reset starts the power-up wait.
    always_ff @(posedge clk) begin
        if (reset) begin
            remain <= `DPC_TMR_W'(`DPC_POWER_CYC);
        end else begin
            remain <= next_remain;
        end
    end
endmodule // dpc_timer

// *** logic/dpc_port_ctrl.sv ***
// Purpose: Host controller driving one port of an asynchronous
//          dual-port static memory through its pins.
// Assumes: Pin inputs are synchronous to clk; one command at a time.
// Notes:   Every pin output is a flip-flop; the busy pin is always an
//          input here, whatever the memory's role strap.
`timescale 1ns/1ps
`include "dpc_consts.svh"

// Summary of operation
// - Memory: chip low; flags: flag select low.
// - Read/write stays high while address changes.
// - Output enable high or pulse stretched during writes.
// - Never drive data while the device drives.
// - Read keeps read/write high, output enable low.
// - Each flag read gets its own select.
// - Chip select high across flag write, read.
// - Wait the flag gap before reading back.
// - Busy pin: master output, slave write gate.
// - Hold write strobe past busy release.
// - Chip select held high during retention.
// - Wait over a read cycle after power returns.
module dpc_port_ctrl (
    input  wire logic                     clk,
    input  wire logic                     reset,
    // User command side.
    input  wire logic                     cmd_valid,
    input  wire dpc_pkg::dpc_op_t         cmd_op,
    input  wire logic [`DPC_ADDR_W-1:0]   cmd_addr,
    input  wire logic [`DPC_DATA_W-1:0]   cmd_wdata,
    input  wire logic [1:0]               cmd_lanes,
    output logic                          cmd_ready,
    output logic                          resp_valid,
    output logic [`DPC_DATA_W-1:0]        resp_data,
    output logic                          busy_held,
    input  wire logic                     supply_ok,
    // Memory port pins.
    output logic [`DPC_ADDR_W-1:0]        mem_addr,
    output logic                          chip_select_n,
    output logic                          read_write,
    output logic                          output_enable_n,
    output logic                          upper_lane_enable_n,
    output logic                          lower_lane_enable_n,
    output logic                          flag_token_select_n,
    input  wire logic [`DPC_DATA_W-1:0]   data_in,
    output logic [`DPC_DATA_W-1:0]        data_out,
    output logic                          data_oe_n,
    input  wire logic                     busy_n
);
    import dpc_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    dpc_state_t                 state;
    dpc_state_t                 next_state;
    dpc_op_t                    op;
    logic [`DPC_DATA_W-1:0]     wdata;
    logic [1:0]                 lanes;
    logic [`DPC_TMR_W-1:0]      gap;
    logic [`DPC_TMR_W-1:0]      next_gap;

    logic                       accept;
    logic                       op_flag;
    logic                       op_write;
    logic                       in_access;
    logic                       next_access;
    logic                       access_done;
    logic                       load_power;
    logic                       next_cmd_ready;
    logic                       next_resp_valid;
    logic [`DPC_ADDR_W-1:0]     next_addr;
    logic                       next_chip_select_n;
    logic                       next_read_write;
    logic                       next_output_enable_n;
    logic                       next_upper_n;
    logic                       next_lower_n;
    logic                       next_flag_n;
    logic                       next_data_oe_n;
    logic [`DPC_TMR_W-1:0]      access_count;
    logic                       stalled;
    logic                       capture_read;

    dpc_timer_if tmr ();

    dpc_timer u_timer (
        .clk   (clk),
        .reset (reset),
        .tmr   (tmr.cnt)
    );

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    assign accept      = (state == DPC_ST_IDLE) && cmd_ready && cmd_valid
                         && supply_ok;
    assign op_flag     = (op == DPC_OP_FLAG_WRITE) ||
                         (op == DPC_OP_FLAG_READ);
    assign op_write    = (op == DPC_OP_WRITE) ||
                         (op == DPC_OP_FLAG_WRITE);
    assign in_access   = (state == DPC_ST_WRITE) || (state == DPC_ST_READ);
    assign next_access = (next_state == DPC_ST_WRITE) ||
                         (next_state == DPC_ST_READ);
    assign access_done = in_access && tmr.done && busy_n;
    assign stalled     = in_access && !busy_n;
    assign load_power  = !supply_ok &&
                         ((state == DPC_ST_IDLE) ||
                          (state == DPC_ST_POWER));

    assign access_count = op_write ? `DPC_TMR_W'(`DPC_WR_ACCESS_CYC)
                                   : `DPC_TMR_W'(`DPC_RD_ACCESS_CYC);

    // ------------------------------------------------------------------
    // Phase timer control
    // ------------------------------------------------------------------
    // Busy low restarts the access count, so a write strobe stays low
    // for at least the hold count after busy returns high.
    assign tmr.load  = (state == DPC_ST_SETUP) ||
                       stalled ||
                       load_power;
    assign tmr.count = load_power ? `DPC_TMR_W'(`DPC_POWER_CYC)
                                  : access_count;

    // ------------------------------------------------------------------
    // State sequencing
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            DPC_ST_IDLE: begin
                if (!supply_ok) begin
                    next_state = DPC_ST_POWER;
                end else if (accept) begin
                    next_state = DPC_ST_SETUP;
                end
            end
            DPC_ST_SETUP: begin
                next_state = op_write ? DPC_ST_WRITE : DPC_ST_READ;
            end
            DPC_ST_WRITE: begin
                if (access_done) begin
                    next_state = DPC_ST_END;
                end
            end
            DPC_ST_READ: begin
                if (access_done) begin
                    next_state = DPC_ST_END;
                end
            end
            DPC_ST_END: begin
                next_state = DPC_ST_IDLE;
            end
            DPC_ST_POWER: begin
                if (supply_ok && tmr.done) begin
                    next_state = DPC_ST_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Flag read-back spacing
    // ------------------------------------------------------------------
    assign next_gap = ((state == DPC_ST_END) && (op == DPC_OP_FLAG_WRITE))
                      ? `DPC_TMR_W'(`DPC_GAP_CYC)
                      : (gap != '0) ? gap - 1'b1 : gap;

    assign next_cmd_ready = (next_state == DPC_ST_IDLE) && (next_gap == '0);

    // ------------------------------------------------------------------
    // Pin values
    // ------------------------------------------------------------------
    // Address only moves on acceptance, while read/write is still high.
    assign next_addr = accept ? cmd_addr : mem_addr;

    // Select and read/write fall on the same edge, so the device keeps
    // its outputs off for the whole write.
    assign next_read_write    = !(next_state == DPC_ST_WRITE);
    assign next_output_enable_n = !(next_state == DPC_ST_READ);
    assign next_chip_select_n = !(next_access && !op_flag);
    assign next_flag_n        = !(next_access && op_flag);
    assign next_upper_n       = !(next_access && !op_flag &&
                                  lanes[`DPC_LANE_UPPER]);
    assign next_lower_n       = !(next_access && !op_flag &&
                                  lanes[`DPC_LANE_LOWER]);

    // Data is driven only in write phases and one cycle beyond, when
    // output enable is high and the device drives nothing.
    assign next_data_oe_n = !((next_state == DPC_ST_WRITE) ||
                              ((next_state == DPC_ST_END) &&
                               op_write));

    assign next_resp_valid = in_access && (next_state == DPC_ST_END);

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state     <= DPC_ST_POWER;
            gap       <= '0;
            cmd_ready <= 1'b0;
        end else begin
            state     <= next_state;
            gap       <= next_gap;
            cmd_ready <= next_cmd_ready;
        end
    end

    // ------------------------------------------------------------------
    // Command capture
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            op    <= DPC_OP_READ;
            wdata <= '0;
            lanes <= 2'h0;
        end else if (accept) begin
            op    <= cmd_op;
            wdata <= cmd_wdata;
            lanes <= cmd_lanes;
        end
    end

    // ------------------------------------------------------------------
    // Pin registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            mem_addr            <= '0;
            chip_select_n       <= 1'b1;
            read_write          <= 1'b1;
            output_enable_n     <= 1'b1;
            flag_token_select_n <= 1'b1;
        end else begin
            mem_addr            <= next_addr;
            chip_select_n       <= next_chip_select_n;
            read_write          <= next_read_write;
            output_enable_n     <= next_output_enable_n;
            flag_token_select_n <= next_flag_n;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            upper_lane_enable_n <= 1'b1;
            lower_lane_enable_n <= 1'b1;
            data_oe_n           <= 1'b1;
        end else begin
            upper_lane_enable_n <= next_upper_n;
            lower_lane_enable_n <= next_lower_n;
            data_oe_n           <= next_data_oe_n;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            data_out <= '0;
        end else begin
            data_out <= wdata;
        end
    end

    // ------------------------------------------------------------------
    // Response and busy status
    // ------------------------------------------------------------------
    assign capture_read = next_resp_valid && !op_write;

    always_ff @(posedge clk) begin
        if (reset) begin
            resp_valid <= 1'b0;
        end else begin
            resp_valid <= next_resp_valid;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            resp_data <= '0;
        end else if (capture_read) begin
            resp_data <= data_in;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            busy_held <= 1'b0;
        end else begin
            busy_held <= stalled;
        end
    end

endmodule // dpc_port_ctrl

// *** testbench/dpc_checker.sv ***
// Purpose: Concurrent checks on the port controller pins.
// Assumes: Synchronous active high reset on clk.
// Notes:   Bound to every controller instance.
`timescale 1ns/1ps
`include "dpc_consts.svh"

module dpc_checker
    import dpc_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   reset,
    input wire logic                   cmd_valid,
    input wire dpc_pkg::dpc_op_t       cmd_op,
    input wire logic                   cmd_ready,
    input wire logic                   supply_ok,
    input wire logic                   resp_valid,
    input wire logic [`DPC_ADDR_W-1:0] mem_addr,
    input wire logic                   chip_select_n,
    input wire logic                   read_write,
    input wire logic                   output_enable_n,
    input wire logic                   flag_token_select_n,
    input wire logic [`DPC_DATA_W-1:0] data_out,
    input wire logic                   data_oe_n,
    input wire logic                   busy_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire take = cmd_valid && cmd_ready && supply_ok;
    wire idle = chip_select_n && flag_token_select_n;

    AST_SELECT_EXCL: assert property (
        !chip_select_n |-> flag_token_select_n)
        else $error("both selects low");
    AST_ADDR_RW: assert property (
        !$stable(mem_addr) |-> read_write && $past(read_write))
        else $error("address moved with strobe low");
    AST_SETUP: assert property (take |=> idle && read_write)
        else $error("no setup cycle after take");
    AST_WRITE_OE: assert property (
        !read_write |-> output_enable_n && !data_oe_n)
        else $error("write without driven data");
    AST_HOLD: assert property (
        $rose(read_write) |-> !data_oe_n && $stable(data_out))
        else $error("data not held past strobe");
    AST_NO_FIGHT: assert property (
        !output_enable_n |-> data_oe_n && read_write)
        else $error("bus contention");
    AST_FLAG_GAP: assert property (
        $rose(flag_token_select_n) |-> flag_token_select_n[*3])
        else $error("flag select too soon");
    AST_RESP_END: assert property (
        resp_valid |-> idle &&
        (!$past(chip_select_n) || !$past(flag_token_select_n)))
        else $error("response without access");
    AST_BUSY_WAIT: assert property (
        $rose(busy_n) && !chip_select_n |-> !chip_select_n[*2])
        else $error("strobe dropped at busy release");
    AST_RETAIN: assert property ((!supply_ok)[*8] |-> idle)
        else $error("access while supply low");
    AST_POWER_WAIT: assert property ($rose(supply_ok) |-> idle[*3])
        else $error("access too soon after supply");

    cover property (take && cmd_op == DPC_OP_FLAG_WRITE);
    cover property (!busy_n && !chip_select_n);
    cover property ($rose(supply_ok));
endmodule // dpc_checker

bind dpc_port_ctrl dpc_checker u_chk (.clk(clk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready),
    .supply_ok(supply_ok), .resp_valid(resp_valid), .mem_addr(mem_addr),
    .chip_select_n(chip_select_n), .read_write(read_write),
    .output_enable_n(output_enable_n),
    .flag_token_select_n(flag_token_select_n), .data_out(data_out),
    .data_oe_n(data_oe_n), .busy_n(busy_n));

// *** testbench/dpc_mem_model.sv ***
// Purpose: Behavioural dual-port memory seen from one port.
// Assumes: The far port is reduced to a select, address and flag request.
// Notes:   Undriven data lines toggle every cycle.
`timescale 1ns/1ps
`include "dpc_consts.svh"

module dpc_mem_model (
    input  wire logic                   clk,
    input  wire logic [`DPC_ADDR_W-1:0] mem_addr,
    input  wire logic                   chip_select_n,
    input  wire logic                   read_write,
    input  wire logic                   output_enable_n,
    input  wire logic                   upper_lane_enable_n,
    input  wire logic                   lower_lane_enable_n,
    input  wire logic                   flag_token_select_n,
    input  wire logic [`DPC_DATA_W-1:0] data_out,
    input  wire logic                   data_oe_n,
    input  wire logic                   other_sel_n,
    input  wire logic [`DPC_ADDR_W-1:0] other_addr,
    input  wire logic                   other_flag_req,
    output logic [`DPC_DATA_W-1:0]      data_in,
    output logic                        busy_n
);
    logic [15:0] ram [0:31];
    logic [1:0]  owner     = 2'h0;
    logic [15:0] last      = 16'h0000;
    logic        far_int_n = 1'b1;
    wire ram_sel  = !chip_select_n && flag_token_select_n;
    wire flag_sel = chip_select_n && !flag_token_select_n;
    wire [4:0] idx = mem_addr[4:0];
    wire drive = (ram_sel || flag_sel) && read_write
                 && !output_enable_n;
    wire [15:0] dev_q = ram_sel ? ram[idx] :
                        {15'h7fff, owner != 2'h1};
    wire clash = ram_sel && !other_sel_n && other_addr == mem_addr;
    assign busy_n = !clash;
    assign data_in = drive ? dev_q : (!data_oe_n ? data_out : ~last);
    wire store = ram_sel && !read_write && busy_n;

    always @(posedge clk) begin
        if (drive || !data_oe_n) last <= data_in;
        else last <= ~last;
        if (store && !upper_lane_enable_n) ram[idx][15:8] <= data_in[15:8];
        if (store && !lower_lane_enable_n) ram[idx][7:0] <= data_in[7:0];
        if (store && mem_addr == 15'h7fff) far_int_n <= 1'b0;
        else if (!other_sel_n && other_addr == 15'h7fff) far_int_n <= 1'b1;
        if (flag_sel && !read_write) begin
            if (!data_in[0] && owner == 2'h0) owner <= 2'h1;
            else if (data_in[0] && owner == 2'h1)
                owner <= other_flag_req ? 2'h2 : 2'h0;
        end else if (other_flag_req && owner == 2'h0) owner <= 2'h2;
        else if (!other_flag_req && owner == 2'h2) owner <= 2'h0;
    end
endmodule // dpc_mem_model

// *** testbench/tb_dpc_port_ctrl.sv ***
// Purpose: Self-checking bench for the port controller.
// Assumes: One far port, modelled beside the memory.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`include "dpc_consts.svh"

module tb_dpc_port_ctrl;
    import dpc_pkg::*;
    logic clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, supply_ok = 1'b1;
    dpc_op_t cmd_op = DPC_OP_READ;
    logic [14:0] cmd_addr = 15'h0000, mem_addr, other_addr = 15'h0000;
    logic [15:0] cmd_wdata = 16'h0000, resp_data, data_in, data_out;
    logic [1:0] cmd_lanes = 2'h3;
    logic other_sel_n = 1'b1, other_flag_req = 1'b0, seen_busy = 1'b0;
    logic cmd_ready, resp_valid, busy_held, chip_select_n, read_write;
    logic output_enable_n, upper_lane_enable_n, lower_lane_enable_n;
    logic flag_token_select_n, data_oe_n, busy_n;
    int mismatches = 0, checked = 0, cycles = 0;

    dpc_port_ctrl dut_u (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_lanes(cmd_lanes), .cmd_ready(cmd_ready),
        .resp_valid(resp_valid), .resp_data(resp_data),
        .busy_held(busy_held), .supply_ok(supply_ok), .mem_addr(mem_addr),
        .chip_select_n(chip_select_n), .read_write(read_write),
        .output_enable_n(output_enable_n),
        .upper_lane_enable_n(upper_lane_enable_n),
        .lower_lane_enable_n(lower_lane_enable_n),
        .flag_token_select_n(flag_token_select_n), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .busy_n(busy_n));
    dpc_mem_model u_mem (.clk(clk), .mem_addr(mem_addr),
        .chip_select_n(chip_select_n), .read_write(read_write),
        .output_enable_n(output_enable_n),
        .upper_lane_enable_n(upper_lane_enable_n),
        .lower_lane_enable_n(lower_lane_enable_n),
        .flag_token_select_n(flag_token_select_n), .data_out(data_out),
        .data_oe_n(data_oe_n), .other_sel_n(other_sel_n),
        .other_addr(other_addr), .other_flag_req(other_flag_req),
        .data_in(data_in), .busy_n(busy_n));

    always #10 clk = ~clk;
    always @(negedge clk) if (busy_held === 1'b1) seen_busy = 1'b1;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (mismatches == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp_word(input string what, input logic [15:0] exp,
                            input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp,
                           input logic got);
        cmp_word(what, {15'h0000, exp}, {15'h0000, got});
    endtask

    // Issues one command and waits for its response.
    task automatic do_cmd(input dpc_op_t op, input logic [14:0] a,
                          input logic [15:0] d, output logic [15:0] q);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        n = 0;
        while (resp_valid !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        q = resp_data;
        cmp_bit("response", 1'b1, resp_valid);
    endtask

    task automatic t_reset_state();
        logic [15:0] q;
        cmp_bit("chip select", 1'b1, chip_select_n);
        repeat (2) @(posedge clk);
        #1;
        cmp_bit("early ready", 1'b0, cmd_ready);
        do_cmd(DPC_OP_READ, 15'h0000, 16'h0000, q);
    endtask

    task automatic t_lanes();
        logic [15:0] q;
        cmd_lanes = 2'h3;
        do_cmd(DPC_OP_WRITE, 15'h0003, 16'ha55a, q);
        cmd_lanes = 2'h2;
        do_cmd(DPC_OP_WRITE, 15'h0003, 16'h1234, q);
        cmd_lanes = 2'h1;
        do_cmd(DPC_OP_WRITE, 15'h0003, 16'hffcc, q);
        cmd_lanes = 2'h3;
        do_cmd(DPC_OP_READ, 15'h0003, 16'h0000, q);
        cmp_word("lane merge", 16'h12cc, q);
    endtask

    task automatic t_addrs();
        logic [14:0] a [4] = '{15'h0000, 15'h7fff, 15'h2aaa, 15'h0015};
        logic [15:0] q;
        foreach (a[i]) begin
            do_cmd(DPC_OP_WRITE, a[i], {a[i][7:0], 8'h5a}, q);
        end
        foreach (a[i]) begin
            do_cmd(DPC_OP_READ, a[i], 16'h0000, q);
            cmp_word("read back", {a[i][7:0], 8'h5a}, q);
        end
        cmp_bit("far interrupt", 1'b0, u_mem.far_int_n);
        other_addr = 15'h7fff;
        other_sel_n = 1'b0;
        @(posedge clk);
        #1;
        other_sel_n = 1'b1;
        cmp_bit("far interrupt clear", 1'b1, u_mem.far_int_n);
    endtask

    task automatic t_flag();
        logic [15:0] q;
        do_cmd(DPC_OP_FLAG_WRITE, 15'h0000, 16'h0000, q);
        do_cmd(DPC_OP_FLAG_READ, 15'h0000, 16'h0000, q);
        cmp_bit("token held", 1'b0, q[0]);
        other_flag_req = 1'b1;
        do_cmd(DPC_OP_FLAG_WRITE, 15'h0000, 16'h0001, q);
        do_cmd(DPC_OP_FLAG_READ, 15'h0000, 16'h0000, q);
        cmp_bit("token passed", 1'b1, q[0]);
        other_flag_req = 1'b0;
        do_cmd(DPC_OP_FLAG_WRITE, 15'h0000, 16'h0000, q);
        do_cmd(DPC_OP_FLAG_READ, 15'h0000, 16'h0000, q);
        cmp_bit("token regained", 1'b0, q[0]);
        do_cmd(DPC_OP_FLAG_WRITE, 15'h0000, 16'h0001, q);
    endtask

    task automatic t_busy();
        logic [15:0] q;
        seen_busy = 1'b0;
        other_addr = 15'h0009;
        other_sel_n = 1'b0;
        do_cmd(DPC_OP_WRITE, 15'h000a, 16'h0bad, q);
        cmp_bit("no busy on mismatch", 1'b0, seen_busy);
        fork
            do_cmd(DPC_OP_WRITE, 15'h0009, 16'hbeef, q);
            begin
                repeat (10) @(posedge clk);
                #1;
                other_sel_n = 1'b1;
            end
        join
        cmp_bit("busy stall", 1'b1, seen_busy);
        do_cmd(DPC_OP_READ, 15'h0009, 16'h0000, q);
        cmp_word("late write", 16'hbeef, q);
    endtask

    task automatic t_supply();
        logic [15:0] q;
        supply_ok = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        cmp_bit("retention select", 1'b1, chip_select_n);
        supply_ok = 1'b1;
        do_cmd(DPC_OP_READ, 15'h0003, 16'h0000, q);
        cmp_word("retained", 16'h12cc, q);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        t_reset_state();
        t_lanes();
        t_addrs();
        t_flag();
        t_busy();
        t_supply();
        print_verdict();
    end
endmodule // tb_dpc_port_ctrl
